/* File: design/fpc_top.sv */
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "fpc_defines.svh"
module fpc_top
  import fpc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [22:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  fpc_state_t state_reg;
  fpc_op_t op_reg;
  fpc_set_t set_reg;
  fpc_step_t step_reg;
  fpc_step_t cur_step;
  logic [2:0] idx_reg;
  logic [3:0] cnt_reg;
  logic start_pend_reg;
  logic done_reg;
  logic err_reg;
  logic [22:0] addr_reg;
  logic [15:0] data_reg;
  logic [15:0] rdata_reg;
  logic wr_pend_reg;
  logic pwd_wait_reg;
  logic [7:0] baddr_reg;
  logic [15:0] mem_rdata;
  logic mem_wen;
  logic eng_wen;
  logic [1:0] mem_waddr;
  logic [1:0] mem_raddr;
  logic [15:0] mem_wdata;
  logic busy;
  logic bus_take;
  logic start_wr;
  logic [31:0] rd_word;

  function automatic logic is_pwd(input logic [7:0] a);
    return a[7:4] == `FPC_OFF_PWD_HI;
  endfunction

  function automatic logic is_enter(input fpc_op_t op);
    return op inside {FPC_OP_ENTER_LOCKREG, FPC_OP_ENTER_PWD, FPC_OP_ENTER_NONVOLATILE_BLOCK_PROTECT_BIT,
                      FPC_OP_ENTER_LOCKBIT, FPC_OP_ENTER_VPB, FPC_OP_ENTER_EXT};
  endfunction

  function automatic fpc_set_t set_of(input fpc_op_t op);
    case (op)
      FPC_OP_ENTER_LOCKREG, FPC_OP_LOCKREG_PROG, FPC_OP_LOCKREG_READ: return FPC_SET_LOCKREG;
      FPC_OP_ENTER_PWD, FPC_OP_PWD_PROG, FPC_OP_PWD_READ, FPC_OP_PWD_UNLOCK: return FPC_SET_PWD;
      FPC_OP_ENTER_NONVOLATILE_BLOCK_PROTECT_BIT, FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_PROG, FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_CLEAR, FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_READ: return FPC_SET_NONVOLATILE_BLOCK_PROTECT_BIT;
      FPC_OP_ENTER_LOCKBIT, FPC_OP_LOCKBIT_PROG, FPC_OP_LOCKBIT_READ: return FPC_SET_LOCKBIT;
      FPC_OP_ENTER_VPB, FPC_OP_VPB_SET, FPC_OP_VPB_CLR, FPC_OP_VPB_READ: return FPC_SET_VPB;
      FPC_OP_ENTER_EXT, FPC_OP_EXT_PROG, FPC_OP_EXT_READ, FPC_OP_EXT_EXIT: return FPC_SET_EXT;
      default: return FPC_SET_NONE;
    endcase
  endfunction

  // An operation may only run in the set it belongs to, exit in any set but the extended one; entries only from read mode.
  function automatic logic allowed(input fpc_op_t op, input fpc_set_t cur);
    if (is_enter(op)) begin
      return cur == FPC_SET_NONE;
    end else if (op == FPC_OP_EXIT_SET) begin
      return (cur != FPC_SET_NONE) && (cur != FPC_SET_EXT); // [R15]
    end else begin
      return (cur != FPC_SET_NONE) && (cur == set_of(op));
    end
  endfunction

  function automatic logic [2:0] last_idx(input fpc_op_t op);
    if (is_enter(op)) begin
      return 3'h2;
    end
    case (op)
      FPC_OP_PWD_READ, FPC_OP_EXT_EXIT: return 3'h3;
      FPC_OP_PWD_UNLOCK: return 3'h6;
      FPC_OP_LOCKREG_READ, FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_READ, FPC_OP_LOCKBIT_READ, FPC_OP_VPB_READ,
      FPC_OP_EXT_READ: return 3'h0;
      default: return 3'h1;
    endcase
  endfunction

  function automatic logic [15:0] enter_code(input fpc_op_t op);
    case (op)
      FPC_OP_ENTER_LOCKREG: return `FPC_CODE_LOCKREG;
      FPC_OP_ENTER_PWD: return `FPC_CODE_PWD;
      FPC_OP_ENTER_NONVOLATILE_BLOCK_PROTECT_BIT: return `FPC_CODE_NONVOLATILE_BLOCK_PROTECT_BIT;
      FPC_OP_ENTER_LOCKBIT: return `FPC_CODE_LOCKBIT;
      FPC_OP_ENTER_VPB: return `FPC_CODE_VPB;
      FPC_OP_ENTER_EXT: return `FPC_CODE_EXT;
      default: return `FPC_CODE_EXIT;
    endcase
  endfunction

  // Address and data of one bus cycle of an operation; pw is the buffered password word.
  function automatic fpc_step_t step_fn(input fpc_op_t op, input logic [2:0] idx, input logic [22:0] a,
                                        input logic [15:0] d, input logic [15:0] pw);
    fpc_step_t s;
    logic [22:0] idx_a;
    s = '{rd: 1'b0, a: 23'h0, d: `FPC_CODE_ZERO};
    idx_a = {20'h0, idx};
    if (is_enter(op) || op == FPC_OP_EXT_EXIT) begin
      if (idx == 3'h0) begin
        s.a = `FPC_U1_ADDR; // [R1]
        s.d = `FPC_U1_DATA;
      end else if (idx == 3'h1) begin
        s.a = `FPC_U2_ADDR; // [R1]
        s.d = `FPC_U2_DATA;
      end else if (idx == 3'h2) begin
        // Only the non-volatile and volatile entries carry the bank in the high lines.
        s.a = (op inside {FPC_OP_ENTER_NONVOLATILE_BLOCK_PROTECT_BIT, FPC_OP_ENTER_VPB}) ? {a[22:16], 16'(`FPC_U1_ADDR)} : `FPC_U1_ADDR; // [R8] [R13] [R16]
        s.d = enter_code(op); // [R1] [R3] [R4] [R11] [R14]
      end
    end else if (idx == 3'h0 && op inside {FPC_OP_LOCKREG_PROG, FPC_OP_PWD_PROG, FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_PROG,
                 FPC_OP_LOCKBIT_PROG, FPC_OP_VPB_SET, FPC_OP_VPB_CLR, FPC_OP_EXT_PROG}) begin
      s.d = `FPC_CODE_PROG; // [R3] [R4] [R8] [R11] [R13] [R14]
    end else begin
      case (op)
        FPC_OP_LOCKREG_PROG: s.d = d; // [R3]
        FPC_OP_PWD_PROG: begin
          s.a = {21'h0, a[1:0]}; // [R4] [R5] [R6]
          s.d = pw;
        end
        FPC_OP_PWD_READ: begin
          s.rd = 1'b1; // [R5] [R17]
          s.a = idx_a;
        end
        FPC_OP_PWD_UNLOCK: begin
          if (idx == 3'h0) begin
            s.d = `FPC_CODE_UNL1; // [R7]
          end else if (idx == 3'h1) begin
            s.d = `FPC_CODE_UNL2;
          end else if (idx == 3'h6) begin
            s.d = `FPC_CODE_UNL_END;
          end else begin
            s.a = 23'(idx_a - 23'h2);
            s.d = pw;
          end
        end
        FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_PROG, FPC_OP_VPB_SET: s.a = a; // [R8] [R13]
        FPC_OP_VPB_CLR: begin
          s.a = a;
          s.d = `FPC_CODE_VPB_CLR; // [R13]
        end
        FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_CLEAR: s.d = (idx == 3'h0) ? `FPC_CODE_CLR1 : `FPC_CODE_CLR2; // [R9]
        FPC_OP_EXT_PROG: begin
          s.a = a; // [R14]
          s.d = d;
        end
        FPC_OP_LOCKREG_READ, FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_READ, FPC_OP_LOCKBIT_READ, FPC_OP_VPB_READ,
        FPC_OP_EXT_READ: begin
          s.rd = 1'b1; // [R3] [R14] [R17]
          s.a = a;
        end
        FPC_OP_EXIT_SET: s.d = (idx == 3'h0) ? `FPC_CODE_EXIT : `FPC_CODE_ZERO; // [R15]
        default: s.d = `FPC_CODE_ZERO;
      endcase
    end
    return s;
  endfunction

  assign busy = start_pend_reg | (state_reg != FPC_S_IDLE);
  assign bus_take = hsel & htrans[1] & hready;
  assign start_wr = wr_pend_reg & (baddr_reg == `FPC_OFF_CTRL) & hwdata[`FPC_CTRL_START_BIT];
  assign cur_step = step_fn(op_reg, idx_reg, addr_reg, data_reg, mem_rdata);

  // Password words live in the buffer; the engine has the read port while busy.
  assign eng_wen = (state_reg == FPC_S_PULSE) && (cnt_reg == 4'h0) && step_reg.rd && (op_reg == FPC_OP_PWD_READ);
  assign mem_wen = eng_wen | (wr_pend_reg & is_pwd(baddr_reg) & ~busy);
  assign mem_waddr = eng_wen ? step_reg.a[1:0] : baddr_reg[3:2];
  assign mem_wdata = eng_wen ? flash_dq_in : hwdata[15:0];
  assign mem_raddr = !busy ? haddr[3:2] : (op_reg == FPC_OP_PWD_UNLOCK) ? 2'(idx_reg - 3'h2) : addr_reg[1:0];

  fpc_word_mem #(.WIDTH(16), .DEPTH(4), .AW(2)) u_pwd_mem (
    .clk(hclk),
    .rst_n(hresetn),
    .wen(mem_wen),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  always_comb begin
    if (haddr[7:0] == `FPC_OFF_CTRL) begin
      rd_word = {27'h0, op_reg};
    end else if (haddr[7:0] == `FPC_OFF_ADDR) begin
      rd_word = {9'h0, addr_reg};
    end else if (haddr[7:0] == `FPC_OFF_DATA) begin
      rd_word = {16'h0, data_reg};
    end else if (haddr[7:0] == `FPC_OFF_STATUS) begin
      rd_word = {25'h0, set_reg, 1'b0, err_reg, done_reg, busy};
    end else if (haddr[7:0] == `FPC_OFF_RDATA) begin
      rd_word = {16'h0, rdata_reg};
    end else begin
      rd_word = 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      baddr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= bus_take & hwrite;
      if (bus_take) begin
        baddr_reg <= haddr[7:0];
      end
    end
  end

  // Password buffer reads take one wait state because the buffer read port is registered.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      pwd_wait_reg <= 1'b0;
      hrdata <= 32'h0;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (bus_take && !hwrite && is_pwd(haddr[7:0])) begin
        hreadyout <= 1'b0;
        pwd_wait_reg <= 1'b1;
      end else if (pwd_wait_reg) begin
        hreadyout <= 1'b1;
        pwd_wait_reg <= 1'b0;
        hrdata <= {16'h0, mem_rdata};
      end else begin
        hreadyout <= 1'b1;
        if (bus_take && !hwrite) begin
          hrdata <= rd_word;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 23'h0;
      data_reg <= 16'h0;
    end else if (wr_pend_reg && !busy) begin
      if (baddr_reg == `FPC_OFF_ADDR) begin
        addr_reg <= hwdata[22:0];
      end else if (baddr_reg == `FPC_OFF_DATA) begin
        data_reg <= hwdata[15:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= FPC_S_IDLE;
      op_reg <= FPC_OP_ENTER_LOCKREG;
      set_reg <= FPC_SET_NONE;
      step_reg <= '0;
      idx_reg <= 3'h0;
      cnt_reg <= 4'h0;
      start_pend_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 16'h0;
      flash_addr <= 23'h0;
      flash_dq_out <= 16'h0;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      case (state_reg)
        FPC_S_IDLE: begin
          if (start_pend_reg) begin
            start_pend_reg <= 1'b0;
            if (allowed(op_reg, set_reg)) begin
              state_reg <= FPC_S_FETCH;
              idx_reg <= 3'h0;
              cnt_reg <= 4'h0;
            end else begin
              err_reg <= 1'b1;
              done_reg <= 1'b1;
            end
          end else if (start_wr) begin
            start_pend_reg <= 1'b1;
            op_reg <= fpc_op_t'(hwdata[4:0]);
            done_reg <= 1'b0;
            err_reg <= 1'b0;
          end
        end
        FPC_S_FETCH: begin
          if (cnt_reg == 4'h0) begin
            cnt_reg <= 4'h1;
          end else begin
            step_reg <= cur_step;
            flash_addr <= cur_step.a;
            flash_dq_out <= cur_step.d; // [R16]
            flash_dq_oe <= ~cur_step.rd; // [R17]
            flash_ce_n <= 1'b0;
            state_reg <= FPC_S_SETUP;
          end
        end
        FPC_S_SETUP: begin
          if (step_reg.rd) begin
            flash_oe_n <= 1'b0; // [R17]
            cnt_reg <= 4'(`FPC_RD_CYC - 1);
          end else begin
            flash_we_n <= 1'b0;
            cnt_reg <= 4'(`FPC_WP_CYC - 1);
          end
          state_reg <= FPC_S_PULSE;
        end
        FPC_S_PULSE: begin
          if (cnt_reg == 4'h0) begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (step_reg.rd) begin
              rdata_reg <= flash_dq_in;
            end
            cnt_reg <= 4'(`FPC_HOLD_CYC - 1);
            state_reg <= FPC_S_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        FPC_S_HOLD: begin
          if (cnt_reg == 4'h0) begin
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            if (idx_reg == last_idx(op_reg)) begin
              state_reg <= FPC_S_IDLE;
              done_reg <= 1'b1;
              if (is_enter(op_reg)) begin
                set_reg <= set_of(op_reg);
              end else if (op_reg inside {FPC_OP_EXIT_SET, FPC_OP_EXT_EXIT}) begin
                set_reg <= FPC_SET_NONE; // [R14] [R15]
              end
            end else begin
              idx_reg <= idx_reg + 3'h1;
              cnt_reg <= 4'h0;
              state_reg <= FPC_S_FETCH;
            end
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: state_reg <= FPC_S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_pulse_at(int unsigned i);
    state_reg == FPC_S_PULSE && idx_reg == i;
  endsequence

  property p_prefix_first; // [R1]
    s_pulse_at(0) ##0 is_enter(op_reg) |-> flash_addr == `FPC_U1_ADDR && flash_dq_out == `FPC_U1_DATA;
  endproperty
  a_prefix_first: assert property (p_prefix_first) else $error("entry first cycle is not AA at 555"); // [R1]

  property p_prefix_code; // [R1]
    s_pulse_at(1) ##0 is_enter(op_reg) ##1 state_reg == FPC_S_PULSE && idx_reg == 3'h1 [*1] ##[1:20] s_pulse_at(2)
      |-> flash_dq_out == enter_code(op_reg) && flash_addr[15:0] == 16'(`FPC_U1_ADDR);
  endproperty
  a_prefix_code: assert property (p_prefix_code) else $error("entry third cycle has wrong code"); // [R1]

  property p_pwd_read_addr; // [R5]
    s_pulse_at(idx_reg) ##0 op_reg == FPC_OP_PWD_READ |-> !flash_oe_n && flash_addr == {20'h0, idx_reg};
  endproperty
  a_pwd_read_addr: assert property (p_pwd_read_addr) else $error("password read at wrong address"); // [R5]

  property p_unlock_end; // [R7]
    s_pulse_at(6) ##0 op_reg == FPC_OP_PWD_UNLOCK |-> flash_dq_out == `FPC_CODE_UNL_END && flash_addr == 23'h0;
  endproperty
  a_unlock_end: assert property (p_unlock_end) else $error("unlock does not end with 29 at 00"); // [R7]

  property p_clear_all; // [R9]
    s_pulse_at(1) ##0 op_reg == FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_CLEAR |-> flash_dq_out == `FPC_CODE_CLR2 && flash_addr == 23'h0;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear all second cycle is not 30 at 00"); // [R9]

  property p_vpb_clear; // [R13]
    s_pulse_at(1) ##0 op_reg == FPC_OP_VPB_CLR |-> flash_dq_out == `FPC_CODE_VPB_CLR && !flash_we_n;
  endproperty
  a_vpb_clear: assert property (p_vpb_clear) else $error("volatile clear data is not 01"); // [R13]

  property p_upper_zero; // [R16]
    !flash_we_n && idx_reg == 3'h0 |-> flash_dq_out[15:8] == 8'h00 && flash_addr[22:16] == 7'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("command cycle drives upper lines"); // [R16]

  property p_read_no_drive; // [R17]
    $fell(flash_oe_n) |-> !flash_dq_oe && flash_we_n && !flash_ce_n ##1 !flash_oe_n;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive) else $error("read cycle with data driven"); // [R17]

  sequence s_exit_last;
    state_reg == FPC_S_HOLD && cnt_reg == 4'h0 && idx_reg == 3'h1 && op_reg == FPC_OP_EXIT_SET;
  endsequence

  property p_exit_clears; // [R15]
    s_exit_last |=> set_reg == FPC_SET_NONE && state_reg == FPC_S_IDLE && done_reg;
  endproperty
  a_exit_clears: assert property (p_exit_clears) else $error("exit did not return to read mode"); // [R15]

  property p_write_pulse; // [R17]
    $fell(flash_we_n) |-> flash_dq_oe ##[1:8] $rose(flash_we_n);
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("write strobe too long or undriven"); // [R17]
endmodule

/* File: design/fpc_defines.svh */
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH
// Functional notes
// R1 - Every set entry is AA at 555, 55 at 2AA, then the set code at 555.
// R2 - While a set is active the device blocks reads and writes of block 0.
// R3 - Code 40 enters lock register set; program is A0 then data at 00; one read.
// R4 - Code 60 enters password set; program is A0 then one word at its word address.
// R5 - One password word per program; password read is four reads at 00 to 03.
// R6 - Password words may be written or read in any order, all four in the end.
// R7 - Unlock is 25, 03 at 00, words 0 to 3 at 00 to 03, then 29 at 00.
// R8 - Code C0 with bank address enters non-volatile set; A0 then 00 protects a block.
// R9 - Clear all non-volatile bits is 80 then 30 at 00; device programs before erasing.
// R10 - A block read in a set returns 00 when protected, 01 when unprotected.
// R11 - Code 50 enters lock bit set; A0 then 00 anywhere sets the global lock bit.
// R12 - In the lock bit set one read at bank address returns the lock bit.
// R13 - Code E0 with bank enters volatile set; A0 then 00 sets, A0 then 01 clears.
// R14 - Code 88 maps extended block; exit is AA, 55, 90 then 00 anywhere.
// R15 - Leaving any set needs 90 then 00; nothing else returns to read mode.
// R16 - Upper data lines and high address lines are ignored in command cycles.
// R17 - Status, password and content steps are read cycles; all others are writes.
// R18 - Device aborts programming password mode bit once non-volatile mode bit is set.
// R19 - With volatile lock boot bit programmed all blocks start volatile-protected.
// R20 - Device discards partial sequences that match no step and keeps read state.
`define FPC_OFF_CTRL 8'h00
`define FPC_OFF_ADDR 8'h04
`define FPC_OFF_DATA 8'h08
`define FPC_OFF_STATUS 8'h0C
`define FPC_OFF_RDATA 8'h10
`define FPC_OFF_PWD_HI 4'h2
`define FPC_CTRL_START_BIT 8
`define FPC_U1_ADDR 23'h000555
`define FPC_U2_ADDR 23'h0002AA
`define FPC_U1_DATA 16'h00AA
`define FPC_U2_DATA 16'h0055
`define FPC_CODE_LOCKREG 16'h0040
`define FPC_CODE_PWD 16'h0060
`define FPC_CODE_NONVOLATILE_BLOCK_PROTECT_BIT 16'h00C0
`define FPC_CODE_LOCKBIT 16'h0050
`define FPC_CODE_VPB 16'h00E0
`define FPC_CODE_EXT 16'h0088
`define FPC_CODE_EXIT 16'h0090
`define FPC_CODE_PROG 16'h00A0
`define FPC_CODE_CLR1 16'h0080
`define FPC_CODE_CLR2 16'h0030
`define FPC_CODE_UNL1 16'h0025
`define FPC_CODE_UNL2 16'h0003
`define FPC_CODE_UNL_END 16'h0029
`define FPC_CODE_ZERO 16'h0000
`define FPC_CODE_VPB_CLR 16'h0001
`define FPC_CLK_NS 25
`define FPC_T_WP_NS 35
`define FPC_T_RD_NS 70
`define FPC_T_HOLD_NS 20
`define FPC_WP_CYC (((`FPC_T_WP_NS) + (`FPC_CLK_NS) - 1) / (`FPC_CLK_NS))
`define FPC_RD_CYC (((`FPC_T_RD_NS) + (`FPC_CLK_NS) - 1) / (`FPC_CLK_NS))
`define FPC_HOLD_CYC (((`FPC_T_HOLD_NS) + (`FPC_CLK_NS) - 1) / (`FPC_CLK_NS))
`endif

/* File: design/fpc_pkg.sv */
package fpc_pkg;
  typedef enum logic [4:0] {
    FPC_OP_ENTER_LOCKREG = 5'h00, FPC_OP_ENTER_PWD = 5'h01, FPC_OP_ENTER_NONVOLATILE_BLOCK_PROTECT_BIT = 5'h02,
    FPC_OP_ENTER_LOCKBIT = 5'h03, FPC_OP_ENTER_VPB = 5'h04, FPC_OP_ENTER_EXT = 5'h05,
    FPC_OP_LOCKREG_PROG = 5'h06, FPC_OP_LOCKREG_READ = 5'h07, FPC_OP_PWD_PROG = 5'h08,
    FPC_OP_PWD_READ = 5'h09, FPC_OP_PWD_UNLOCK = 5'h0A, FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_PROG = 5'h0B,
    FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_CLEAR = 5'h0C, FPC_OP_NONVOLATILE_BLOCK_PROTECT_BIT_READ = 5'h0D, FPC_OP_LOCKBIT_PROG = 5'h0E,
    FPC_OP_LOCKBIT_READ = 5'h0F, FPC_OP_VPB_SET = 5'h10, FPC_OP_VPB_CLR = 5'h11,
    FPC_OP_VPB_READ = 5'h12, FPC_OP_EXT_PROG = 5'h13, FPC_OP_EXT_READ = 5'h14,
    FPC_OP_EXT_EXIT = 5'h15, FPC_OP_EXIT_SET = 5'h16
  } fpc_op_t;

  typedef enum logic [2:0] {
    FPC_SET_NONE = 3'h0, FPC_SET_LOCKREG = 3'h1, FPC_SET_PWD = 3'h2, FPC_SET_NONVOLATILE_BLOCK_PROTECT_BIT = 3'h3,
    FPC_SET_LOCKBIT = 3'h4, FPC_SET_VPB = 3'h5, FPC_SET_EXT = 3'h6
  } fpc_set_t;

  typedef enum logic [4:0] {
    FPC_S_IDLE = 5'h01, FPC_S_FETCH = 5'h02, FPC_S_SETUP = 5'h04, FPC_S_PULSE = 5'h08, FPC_S_HOLD = 5'h10
  } fpc_state_t;

  typedef struct packed {
    logic rd;
    logic [22:0] a;
    logic [15:0] d;
  } fpc_step_t;
endpackage

/* File: design/fpc_word_mem.sv */
`timescale 1ns/10ps
module fpc_word_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wen,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk) begin
    if (wen) begin
      mem_reg[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem_reg[raddr];
    end
  end
endmodule

/* File: bench/fpc_flash_model.sv */
`timescale 1ns/10ps
module fpc_flash_model (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [22:0] addr,
  input wire logic [15:0] dq_out,
  output logic [15:0] dq_in
);
  logic [22:0] wa [0:15];
  logic [15:0] wd [0:15];
  logic [15:0] pw [0:3] = '{default: 16'h3C3C};
  logic [127:0] nv = '1;
  logic [15:0] lr = 16'hFFFF;
  logic [127:0] vp;
  logic lb = 1'b1;
  initial vp = {128{~lr[4]}};
  logic [19:0] h1 = 20'h0;
  logic [19:0] h2 = 20'h0;
  logic [7:0] sc = 8'h0;
  logic [7:0] d;
  logic [15:0] rv;
  int n = 0;
  always @(posedge we_n) begin
    if (!ce_n) begin
      d = dq_out[7:0];
      wa[n] = addr;
      wd[n] = dq_out;
      n++;
      if (h2 == 20'h555AA && h1 == 20'h2AA55 && addr[11:0] == 12'h555) begin
        sc = d;
      end else if (h1[7:0] == 8'h90 && d == 8'h00) begin
        sc = 8'h00;
      end else if (h1[7:0] == 8'hA0 && sc == 8'hC0) begin
        nv[addr[22:16]] = 1'b0;
      end else if (h1[7:0] == 8'h80 && d == 8'h30 && sc == 8'hC0) begin
        nv = '1;
      end else if (h1[7:0] == 8'hA0 && sc == 8'h60) begin
        pw[addr[1:0]] = dq_out;
      end else if (h1[7:0] == 8'hA0 && sc == 8'h40) begin
        if (lr[1] || dq_out[2]) begin
          lr = lr & dq_out;
        end
      end else if (h1[7:0] == 8'hA0 && sc == 8'h50) begin
        lb = 1'b0;
      end else if (h1[7:0] == 8'hA0 && sc == 8'hE0) begin
        vp[addr[22:16]] = !d[0];
      end
      // A prefix that breaks off simply ages out of the history.
      h2 = h1;
      h1 = {addr[11:0], d};
    end
  end
  always @* begin
    rv = (sc == 8'hC0) ? {15'h0, nv[addr[22:16]]} :
         (sc == 8'hE0) ? {15'h0, ~vp[addr[22:16]]} :
         (sc == 8'h50) ? {15'h0, lb} :
         (sc == 8'h40) ? lr : pw[addr[1:0]];
  end
  // Released lines show the inverse, so a late sample cannot match by luck.
  assign dq_in = (!ce_n && !oe_n) ? rv : ~rv;
endmodule

/* File: bench/fpc_top_tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module fpc_top_tb;
  import fpc_pkg::*;
  logic hclk = 0;
  logic hresetn = 0;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [31:0] hwdata = 0;
  logic hreadyout, hresp, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
  logic [31:0] hrdata, st, q;
  logic [22:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  int miscompares = 0;
  int n_tests = 0;
  logic [7:0] codes [0:5] = '{8'h40, 8'h60, 8'hC0, 8'h50, 8'hE0, 8'h88};
  logic [1:0] ord [0:3] = '{2'h3, 2'h1, 2'h0, 2'h2};
  logic [1:0] ua [0:6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  logic [15:0] ud [0:6] = '{16'h0025, 16'h0003, 16'h1234, 16'h1235, 16'h1236, 16'h1237, 16'h0029};
  fpc_top i_fpc_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
  fpc_flash_model i_fpc_flash_model (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr),
    .dq_out(flash_dq_out), .dq_in(flash_dq_in));
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wrdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    wrdy();
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
    r = hrdata;
  endtask
  task automatic op(input logic [4:0] o, input logic [22:0] a, input logic [15:0] d, input logic e);
    int k;
    i_fpc_flash_model.n = 0;
    bus(1'b1, 8'h04, {9'h0, a}, q);
    bus(1'b1, 8'h08, {16'h0, d}, q);
    bus(1'b1, 8'h00, {23'h0, 1'b1, 3'h0, o}, q);
    repeat (3) @(posedge hclk);
    k = 0;
    st = 32'h0;
    while (st[1] !== 1'b1 && k < 200) begin
      bus(1'b0, 8'h0C, 32'h0, st);
      k++;
    end
    if (st[1] !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
    `CHK("error", e, st[2])
  endtask
  task automatic ew(input int i, input logic [22:0] a, input logic [15:0] d);
    if (a !== 23'h7FFFFF) `CHK("waddr", a, i_fpc_flash_model.wa[i])
    `CHK("wdata", d, i_fpc_flash_model.wd[i])
  endtask
  task automatic pp(input logic [4:0] o, input logic [22:0] a, input logic [15:0] d, input logic [15:0] ed);
    op(o, a, d, 1'b0);
    ew(0, 23'h7FFFFF, 16'h00A0);
    ew(1, a, ed);
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK("ce_n", 1'b1, flash_ce_n)
    for (int i = 0; i < 6; i++) begin
      op(i[4:0], 23'h050000, 16'h0, 1'b0);
      `CHK("set", i[2:0] + 3'h1, st[6:4])
      ew(0, 23'h000555, 16'h00AA);
      ew(1, 23'h0002AA, 16'h0055);
      ew(2, (i == 2 || i == 4) ? 23'h050555 : 23'h000555, {8'h0, codes[i]});
      op((i == 5) ? 5'h15 : 5'h16, 23'h0, 16'h0, 1'b0);
      ew(i_fpc_flash_model.n - 2, 23'h7FFFFF, 16'h0090);
      ew(i_fpc_flash_model.n - 1, 23'h7FFFFF, 16'h0000);
      `CHK("nw", (i == 5) ? 4 : 2, i_fpc_flash_model.n)
      `CHK("exit", 3'h0, st[6:4])
    end
    op(5'h00, 23'h0, 16'h0, 1'b0);
    pp(5'h06, 23'h0, 16'h00EF, 16'h00EF);
    op(5'h07, 23'h0, 16'h0, 1'b0);
    bus(1'b0, 8'h10, 32'h0, q);
    `CHK("lockreg", 32'h00EF, q)
    op(5'h01, 23'h0, 16'h0, 1'b1);
    op(5'h16, 23'h0, 16'h0, 1'b0);
    op(5'h01, 23'h0, 16'h0, 1'b0);
    foreach (ord[j]) begin
      bus(1'b1, 8'h20 + {4'h0, ord[j], 2'h0}, 32'h1234 + ord[j], q);
      pp(5'h08, {21'h0, ord[j]}, 16'h0, 16'h1234 + ord[j]);
    end
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'h20 + 8'(k * 4), 32'h0, q);
    end
    op(5'h09, 23'h0, 16'h0, 1'b0);
    `CHK("nw", 0, i_fpc_flash_model.n)
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, 8'h20 + 8'(k * 4), 32'h0, q);
      `CHK("pwd", 32'h1234 + k, q)
    end
    op(5'h0A, 23'h0, 16'h0, 1'b0);
    `CHK("nw", 7, i_fpc_flash_model.n)
    foreach (ua[j]) ew(j, {21'h0, ua[j]}, ud[j]);
    op(5'h16, 23'h0, 16'h0, 1'b0);
    op(5'h02, 23'h050000, 16'h0, 1'b0);
    pp(5'h0B, 23'h070010, 16'h0, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        op(5'h0C, 23'h0, 16'h0, 1'b0);
        ew(0, 23'h7FFFFF, 16'h0080);
        ew(1, 23'h0, 16'h0030);
      end
      op(5'h0D, (k == 1) ? 23'h060000 : 23'h070010, 16'h0, 1'b0);
      bus(1'b0, 8'h10, 32'h0, q);
      `CHK("prot", (k == 0) ? 32'h0 : 32'h1, q)
    end
    op(5'h16, 23'h0, 16'h0, 1'b0);
    op(5'h04, 23'h050000, 16'h0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      pp(5'h10 + 5'(k), 23'h070010, 16'h0, 16'(k));
      op(5'h12, 23'h070010, 16'h0, 1'b0);
      bus(1'b0, 8'h10, 32'h0, q);
      `CHK("vprot", 32'(k), q)
    end
    op(5'h16, 23'h0, 16'h0, 1'b0);
    op(5'h03, 23'h0, 16'h0, 1'b0);
    op(5'h0E, 23'h0, 16'h0, 1'b0);
    ew(0, 23'h7FFFFF, 16'h00A0);
    ew(1, 23'h7FFFFF, 16'h0000);
    op(5'h0F, 23'h050000, 16'h0, 1'b0);
    bus(1'b0, 8'h10, 32'h0, q);
    `CHK("lockbit", 32'h0, q)
    op(5'h16, 23'h0, 16'h0, 1'b0);
    `CHK("hresp", 1'b0, hresp)
    give_verdict();
  end
endmodule
